// ===== src/iafp_buf_if.sv
// interface: page buffer access between sequencer and buffer
`timescale 1ns/100ps
interface iafp_buf_if;
  import iafp_pkg::*;
  logic wrEn;
  logic [IDX_W-1:0] wrIdx;
  logic [WORD_W-1:0] wrData;
  logic clrStart;
  logic clrBusy;
  logic clrDone;
  logic [IDX_W-1:0] rdIdx;
  logic [WORD_W-1:0] rdData;
  modport seq (output wrEn, wrIdx, wrData, clrStart, rdIdx, input clrBusy, clrDone, rdData);
  modport buffer (input wrEn, wrIdx, wrData, clrStart, rdIdx, output clrBusy, clrDone, rdData);
endinterface : iafp_buf_if

// ===== src/iafp_page_buf.sv
// module: 64-word page buffer with word-by-word clear
`timescale 1ns/100ps
module iafp_page_buf import iafp_pkg::*; #(
  parameter int DEPTH = PAGE_WORDS
) (
  // system
  input wire logic clock,
  input wire logic nrst,
  // buffer port
  iafp_buf_if.buffer bus
);
  logic [WORD_W-1:0] mem [0:DEPTH-1];
  logic clrBusy_q;
  logic clrDone_q;
  logic [IDX_W-1:0] clrIdx_q;

  // clearing walks every word, one per cycle
  always_ff @(posedge clock) begin
    if (!nrst) begin
      clrBusy_q <= 1'b0;
      clrIdx_q <= IDX_FIRST;
      clrDone_q <= 1'b0;
    end else begin
      clrDone_q <= 1'b0;
      if (bus.clrStart && !clrBusy_q) begin
        clrBusy_q <= 1'b1;
        clrIdx_q <= IDX_FIRST;
      end else if (clrBusy_q) begin
        clrIdx_q <= clrIdx_q + 6'h01;
        if (clrIdx_q == IDX_LAST) begin
          clrBusy_q <= 1'b0;
          clrDone_q <= 1'b1;
        end
      end
    end
  end

  // clear has priority over a load
  always_ff @(posedge clock) begin
    if (clrBusy_q) begin
      mem[clrIdx_q] <= '0;
    end else if (bus.wrEn) begin
      mem[bus.wrIdx] <= bus.wrData;
    end
  end

  assign bus.rdData = mem[bus.rdIdx];
  assign bus.clrBusy = clrBusy_q;
  assign bus.clrDone = clrDone_q;

  clear_span_a: assert property (@(posedge clock) disable iff (!nrst)
    $rose(clrBusy_q) |-> ##63 clrBusy_q ##1 (!clrBusy_q && clrDone_q))
    else $error("buffer clear did not take 64 cycles");
endmodule : iafp_page_buf

// ===== src/iafp_pkg.sv
// package: constants, register map and types of the flash programmer
package iafp_pkg;
  // page geometry
  localparam int PAGE_WORDS = 64;
  localparam int WORD_W = 16;
  localparam int IDX_W = 6;
  localparam int PAGE_W = 9;
  localparam int ADDR_W = 15;
  localparam int BYTE_W = 8;
  localparam logic [IDX_W-1:0] IDX_LAST = 6'h3f;
  localparam logic [IDX_W-1:0] IDX_FIRST = 6'h00;
  localparam logic [BYTE_W-1:0] REG_RESET = 8'h00;

  // sector select values
  localparam logic SECTOR_DIRECT = 1'b0;
  localparam logic SECTOR_EXT = 1'b1;

  // sector 0 offsets
  localparam logic [7:0] OFS_ADDR_LO = 8'h00;
  localparam logic [7:0] OFS_ADDR_HI = 8'h01;
  localparam logic [7:0] OFS_DATA_BASE = 8'h02;
  localparam logic [7:0] OFS_DATA_LAST = 8'h09;
  localparam logic [2:0] DIDX_D0_LO = 3'h0;
  localparam logic [2:0] DIDX_D0_HI = 3'h1;
  localparam logic [2:0] DIDX_D1_LO = 3'h2;
  localparam logic [2:0] DIDX_D1_HI = 3'h3;
  localparam logic [2:0] DIDX_D2_LO = 3'h4;
  localparam logic [2:0] DIDX_D2_HI = 3'h5;
  localparam logic [2:0] DIDX_D3_LO = 3'h6;
  localparam logic [2:0] DIDX_D3_HI = 3'h7;

  // sector 1 offsets
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_CTRL1 = 8'h01;
  localparam logic [7:0] OFS_CTRL2 = 8'h02;

  // control 0 fields
  localparam int C0_ENABLED = 7;
  localparam int C0_MODE_HI = 6;
  localparam int C0_MODE_LO = 4;
  localparam int C0_TRIG = 3;
  localparam int C0_PROG = 2;
  localparam int C0_RDEN = 1;
  localparam int C0_RD = 0;
  // control 2 fields
  localparam int C2_TSEL = 1;
  localparam int C2_CLR = 0;
  // address high: top bit unimplemented
  localparam int AH_BITS = 7;

  // operation mode codes
  localparam logic [2:0] MODE_PROG = 3'h0;
  localparam logic [2:0] MODE_ERASE = 3'h1;
  localparam logic [2:0] MODE_READ = 3'h3;
  localparam logic [2:0] MODE_UNLOCK = 3'h6;

  typedef enum logic [2:0] {
    ST_IDLE, ST_PROG_SEND, ST_PROG_WAIT, ST_ERASE_WAIT, ST_READ_WAIT, ST_AUTO_CLR
  } iafp_state_t;
endpackage : iafp_pkg

// ===== src/iafp_top.sv
// module: in-application flash programmer sequencer and register file
// Function
// - erase/program whole page, read one word
// - page and buffer hold 64 16-bit words
// - enabled status set only after unlock
// - buffer loads ignored unless enabled status high
// - program-start held high until the post-program buffer clear is done
// - read needs read-enable; read-start self-clears
// - high register plus low[7:6] form page
// - clear-buffer bit self-clears after clear finishes
// - buffer maps to page from bits 14:6
// - first data high write loads word, increments
// - word address saturates at last page word
// - buffer auto-cleared after each program
// - two address, four data pairs, three controls
// - address/data in sector 0, controls sector 1
// - address high top bit reads zero
// - three-bit mode: program, erase, read, unlock
// - software may clear enabled status, never set
// - unlock trigger runs timer, clears on timeout
// - cpu stalled while operation in progress
`timescale 1ns/100ps
module iafp_top import iafp_pkg::*; #(
  parameter int UNLOCK_CYCLES = 1024,
  parameter logic [WORD_W-1:0] UNLOCK_PAT1 = 16'h1111, // arbitrary value
  parameter logic [WORD_W-1:0] UNLOCK_PAT2 = 16'h2222, // arbitrary value
  parameter logic [WORD_W-1:0] UNLOCK_PAT3 = 16'h3333  // arbitrary value
) (
  // system
  input wire logic clock,
  input wire logic nrst,
  // special register access
  input wire logic sfrWr,
  input wire logic sfrSector,
  input wire logic [7:0] sfrAddr,
  input wire logic [BYTE_W-1:0] sfrWdata,
  output logic [BYTE_W-1:0] sfrRdata,
  // cpu
  output logic cpuStall,
  // flash array
  output logic flashWrStb,
  output logic flashEraseStb,
  output logic flashRdStb,
  output logic [ADDR_W-1:0] flashAddr,
  output logic [WORD_W-1:0] flashWdata,
  output logic flashTimeSel,
  input wire logic flashDone,
  input wire logic [WORD_W-1:0] flashRdData
);
  ////////////////////////////////////////////////////////////////////////////////
  // declarations
  iafp_buf_if bufBus ();
  iafp_state_t state_q;
  logic [BYTE_W-1:0] addrLo_q;
  logic [AH_BITS-1:0] addrHi_q;
  logic [BYTE_W-1:0] data_q [0:7];
  logic program_enabled_status_q;
  logic [2:0] mode_q;
  logic trig_q;
  logic fwt_q;
  logic rden_q;
  logic frd_q;
  logic [BYTE_W-1:0] ctrl1_q;
  logic tsel_q;
  logic clear_buffer_q;
  logic [IDX_W-1:0] sendIdx_q;
  logic [BYTE_W-1:0] sfrRdata_q;
  logic cpuStall_q;
  logic flashWrStb_q;
  logic flashEraseStb_q;
  logic flashRdStb_q;
  logic [ADDR_W-1:0] flashAddr_q;
  logic [WORD_W-1:0] flashWdata_q;
  logic wrDirect;
  logic wrCtrl0;
  logic wrCtrl2;
  logic loadWord;
  logic unlockOk;
  logic timerExpire;
  logic startProg;
  logic startErase;
  logic startRead;
  logic progDone;
  logic [2:0] wrMode;
  logic [PAGE_W-1:0] pageSel;

  function automatic logic isData(input logic sector, input logic [7:0] ofs);
    isData = (sector == SECTOR_DIRECT) && (ofs >= OFS_DATA_BASE) && (ofs <= OFS_DATA_LAST);
  endfunction : isData

  function automatic logic [2:0] dataIdx(input logic [7:0] ofs);
    dataIdx = 3'(ofs - OFS_DATA_BASE);
  endfunction : dataIdx

  ////////////////////////////////////////////////////////////////////////////////
  // access decode
  assign wrDirect = sfrWr && (sfrSector == SECTOR_DIRECT);
  assign wrCtrl0 = sfrWr && (sfrSector == SECTOR_EXT) && (sfrAddr == OFS_CTRL0);
  assign wrCtrl2 = sfrWr && (sfrSector == SECTOR_EXT) && (sfrAddr == OFS_CTRL2);
  assign wrMode = sfrWdata[C0_MODE_HI:C0_MODE_LO];
  assign pageSel = {addrHi_q, addrLo_q[BYTE_W-1:IDX_W]};
  // a word is taken only once erase/program is enabled and no clear runs
  assign loadWord = isData(sfrSector, sfrAddr) && sfrWr && (dataIdx(sfrAddr) == DIDX_D0_HI)
                    && program_enabled_status_q && !bufBus.clrBusy;
  assign startProg = wrCtrl0 && sfrWdata[C0_PROG] && (wrMode == MODE_PROG) && program_enabled_status_q
                     && (state_q == ST_IDLE) && !bufBus.clrBusy;
  assign startErase = wrCtrl0 && sfrWdata[C0_PROG] && (wrMode == MODE_ERASE) && program_enabled_status_q
                      && (state_q == ST_IDLE) && !bufBus.clrBusy;
  assign startRead = wrCtrl0 && sfrWdata[C0_RD] && (wrMode == MODE_READ) && rden_q
                     && (state_q == ST_IDLE);
  assign unlockOk = trig_q && (mode_q == MODE_UNLOCK)
                    && ({data_q[DIDX_D1_HI], data_q[DIDX_D1_LO]} == UNLOCK_PAT1)
                    && ({data_q[DIDX_D2_HI], data_q[DIDX_D2_LO]} == UNLOCK_PAT2)
                    && ({data_q[DIDX_D3_HI], data_q[DIDX_D3_LO]} == UNLOCK_PAT3);
  assign progDone = (state_q == ST_PROG_WAIT) && flashDone;

  ////////////////////////////////////////////////////////////////////////////////
  // buffer and unlock timer
  assign bufBus.wrEn = loadWord;
  assign bufBus.wrIdx = addrLo_q[IDX_W-1:0];
  assign bufBus.wrData = {sfrWdata, data_q[DIDX_D0_LO]};
  assign bufBus.clrStart = progDone || (wrCtrl2 && sfrWdata[C2_CLR] && !clear_buffer_q);
  assign bufBus.rdIdx = sendIdx_q;

  iafp_page_buf #(.DEPTH(PAGE_WORDS)) u_buf (
    .clock(clock),
    .nrst(nrst),
    .bus(bufBus.buffer)
  );

  iafp_unlock_timer #(.CYCLES(UNLOCK_CYCLES)) u_timer (
    .clock(clock),
    .nrst(nrst),
    .start(wrCtrl0 && sfrWdata[C0_TRIG] && !trig_q),
    .stop(unlockOk),
    .expire(timerExpire)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // address pair
  always_ff @(posedge clock) begin
    if (!nrst) begin
      addrLo_q <= REG_RESET;
      addrHi_q <= REG_RESET[AH_BITS-1:0];
    end else if (loadWord) begin
      if (addrLo_q[IDX_W-1:0] != IDX_LAST) begin
        addrLo_q <= addrLo_q + 8'h01;
      end // last word: hold, no carry into the page bits
    end else if (wrDirect && sfrAddr == OFS_ADDR_LO) begin
      addrLo_q <= sfrWdata;
    end else if (wrDirect && sfrAddr == OFS_ADDR_HI) begin
      addrHi_q <= sfrWdata[AH_BITS-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // data pairs
  always_ff @(posedge clock) begin
    if (!nrst) begin
      for (int i = 0; i < 8; i++) begin
        data_q[i] <= REG_RESET;
      end
    end else if ((state_q == ST_READ_WAIT) && flashDone) begin
      data_q[DIDX_D0_LO] <= flashRdData[BYTE_W-1:0];
      data_q[DIDX_D0_HI] <= flashRdData[WORD_W-1:BYTE_W];
    end else if (sfrWr && isData(sfrSector, sfrAddr)) begin
      data_q[dataIdx(sfrAddr)] <= sfrWdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control 0: enable status, mode and trigger
  always_ff @(posedge clock) begin
    if (!nrst) begin
      program_enabled_status_q <= 1'b0;
      mode_q <= MODE_PROG;
      trig_q <= 1'b0;
      rden_q <= 1'b0;
    end else begin
      if (wrCtrl0) begin
        mode_q <= wrMode;
        rden_q <= sfrWdata[C0_RDEN];
      end
      // hardware set beats a software clear in the same cycle
      if (unlockOk) begin
        program_enabled_status_q <= 1'b1;
      end else if (wrCtrl0 && !sfrWdata[C0_ENABLED]) begin
        program_enabled_status_q <= 1'b0;
      end
      if (unlockOk || timerExpire) begin
        trig_q <= 1'b0;
      end else if (wrCtrl0 && sfrWdata[C0_TRIG]) begin
        trig_q <= 1'b1;
      end
    end
  end

  // start bits: set only when accepted, cleared by hardware at completion
  always_ff @(posedge clock) begin
    if (!nrst) begin
      fwt_q <= 1'b0;
      frd_q <= 1'b0;
    end else begin
      if (startProg || startErase) begin
        fwt_q <= 1'b1;
      end else if ((state_q == ST_AUTO_CLR && bufBus.clrDone)
                   || (state_q == ST_ERASE_WAIT && flashDone)) begin
        fwt_q <= 1'b0;
      end
      if (startRead) begin
        frd_q <= 1'b1;
      end else if (state_q == ST_READ_WAIT && flashDone) begin
        frd_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control 1 and control 2
  always_ff @(posedge clock) begin
    if (!nrst) begin
      ctrl1_q <= REG_RESET;
      tsel_q <= 1'b0;
      clear_buffer_q <= 1'b0;
    end else begin
      if (sfrWr && sfrSector == SECTOR_EXT && sfrAddr == OFS_CTRL1) begin
        ctrl1_q <= sfrWdata;
      end
      if (wrCtrl2) begin
        tsel_q <= sfrWdata[C2_TSEL];
      end
      if (wrCtrl2 && sfrWdata[C2_CLR] && !clear_buffer_q) begin
        clear_buffer_q <= 1'b1;
      end else if (clear_buffer_q && bufBus.clrDone) begin
        clear_buffer_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      sendIdx_q <= IDX_FIRST;
    end else begin
      case (state_q)
        ST_IDLE: begin
          sendIdx_q <= IDX_FIRST;
          if (startProg) begin
            state_q <= ST_PROG_SEND;
          end else if (startErase) begin
            state_q <= ST_ERASE_WAIT;
          end else if (startRead) begin
            state_q <= ST_READ_WAIT;
          end
        end
        ST_PROG_SEND: begin
          sendIdx_q <= sendIdx_q + 6'h01;
          if (sendIdx_q == IDX_LAST) begin
            state_q <= ST_PROG_WAIT;
          end
        end
        ST_PROG_WAIT: begin
          if (flashDone) begin
            state_q <= ST_AUTO_CLR;
          end
        end
        ST_AUTO_CLR: begin
          if (bufBus.clrDone) begin
            state_q <= ST_IDLE;
          end
        end
        ST_ERASE_WAIT, ST_READ_WAIT: begin
          if (flashDone) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // flash array strobes: erase and read one cycle each, write held high for the 64-cycle word burst
  always_ff @(posedge clock) begin
    if (!nrst) begin
      flashWrStb_q <= 1'b0;
      flashEraseStb_q <= 1'b0;
      flashRdStb_q <= 1'b0;
      flashAddr_q <= '0;
      flashWdata_q <= '0;
    end else begin
      flashWrStb_q <= (state_q == ST_PROG_SEND);
      flashEraseStb_q <= startErase;
      flashRdStb_q <= startRead;
      if (state_q == ST_PROG_SEND) begin
        flashAddr_q <= {pageSel, sendIdx_q};
        flashWdata_q <= bufBus.rdData;
      end else if (startErase) begin
        flashAddr_q <= {pageSel, IDX_FIRST};
      end else if (startRead) begin
        flashAddr_q <= {pageSel, addrLo_q[IDX_W-1:0]};
      end
    end
  end

  // cpu stall for the whole operation
  always_ff @(posedge clock) begin
    if (!nrst) begin
      cpuStall_q <= 1'b0;
    end else begin
      cpuStall_q <= startProg || startErase || startRead
                    || ((state_q != ST_IDLE) && !(state_q == ST_AUTO_CLR && bufBus.clrDone)
                        && !((state_q == ST_ERASE_WAIT || state_q == ST_READ_WAIT)
                             && flashDone));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register read-back, one cycle after the address
  always_ff @(posedge clock) begin
    if (!nrst) begin
      sfrRdata_q <= REG_RESET;
    end else if (isData(sfrSector, sfrAddr)) begin
      sfrRdata_q <= data_q[dataIdx(sfrAddr)];
    end else if (sfrSector == SECTOR_DIRECT && sfrAddr == OFS_ADDR_LO) begin
      sfrRdata_q <= addrLo_q;
    end else if (sfrSector == SECTOR_DIRECT && sfrAddr == OFS_ADDR_HI) begin
      sfrRdata_q <= {1'b0, addrHi_q};
    end else if (sfrSector == SECTOR_EXT && sfrAddr == OFS_CTRL0) begin
      sfrRdata_q <= {program_enabled_status_q, mode_q, trig_q, fwt_q, rden_q, frd_q};
    end else if (sfrSector == SECTOR_EXT && sfrAddr == OFS_CTRL1) begin
      sfrRdata_q <= ctrl1_q;
    end else if (sfrSector == SECTOR_EXT && sfrAddr == OFS_CTRL2) begin
      sfrRdata_q <= {6'h00, tsel_q, clear_buffer_q};
    end else begin
      sfrRdata_q <= REG_RESET;
    end
  end

  assign sfrRdata = sfrRdata_q;
  assign cpuStall = cpuStall_q;
  assign flashWrStb = flashWrStb_q;
  assign flashEraseStb = flashEraseStb_q;
  assign flashRdStb = flashRdStb_q;
  assign flashAddr = flashAddr_q;
  assign flashWdata = flashWdata_q;
  assign flashTimeSel = tsel_q;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  enable_gate_a: assert property (@(posedge clock) disable iff (!nrst)
    $rose(program_enabled_status_q) |-> $past(unlockOk)) else $error("enable rose without unlock");
  load_gate_a: assert property (@(posedge clock) disable iff (!nrst)
    !program_enabled_status_q |-> !bufBus.wrEn) else $error("buffer loaded while disabled");
  addr_step_a: assert property (@(posedge clock) disable iff (!nrst)
    (loadWord && addrLo_q[IDX_W-1:0] != IDX_LAST) |=> addrLo_q == $past(addrLo_q) + 8'h01)
    else $error("address did not step on word load");
  addr_hold_a: assert property (@(posedge clock) disable iff (!nrst)
    (loadWord && addrLo_q[IDX_W-1:0] == IDX_LAST) |=> $stable(addrLo_q) && $stable(addrHi_q))
    else $error("address moved past last word");
  prog_burst_a: assert property (@(posedge clock) disable iff (!nrst)
    startProg |=> fwt_q && cpuStall_q ##1 flashWrStb_q [*8])
    else $error("program burst did not begin");
  read_land_a: assert property (@(posedge clock) disable iff (!nrst)
    (state_q == ST_READ_WAIT && flashDone) |=> !frd_q
      && {data_q[DIDX_D0_HI], data_q[DIDX_D0_LO]} == $past(flashRdData))
    else $error("read word not placed");
  trig_drop_a: assert property (@(posedge clock) disable iff (!nrst)
    timerExpire |=> !trig_q) else $error("trigger not cleared on timeout");
  stall_busy_a: assert property (@(posedge clock) disable iff (!nrst)
    (state_q == ST_PROG_WAIT || state_q == ST_ERASE_WAIT) |-> cpuStall_q)
    else $error("cpu not stalled during operation");
  auto_clear_a: assert property (@(posedge clock) disable iff (!nrst)
    progDone |=> bufBus.clrBusy ##[63:64] bufBus.clrDone)
    else $error("buffer not cleared after program");
endmodule : iafp_top

// ===== src/iafp_unlock_timer.sv
// module: unlock window timer, one expiry pulse per started window that runs out without a stop
`timescale 1ns/100ps
module iafp_unlock_timer #(
  parameter int CYCLES = 1024
) (
  // system
  input wire logic clock,
  input wire logic nrst,
  // control
  input wire logic start,
  input wire logic stop,
  // status
  output logic expire
);
  localparam int CNT_W = $clog2(CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(CYCLES);
  logic [CNT_W-1:0] cnt_q;
  logic expire_q;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      cnt_q <= CNT_ZERO;
      expire_q <= 1'b0;
    end else begin
      expire_q <= 1'b0;
      if (stop) begin
        cnt_q <= CNT_ZERO;
      end else if (start) begin
        cnt_q <= CNT_LOAD;
      end else if (cnt_q != CNT_ZERO) begin
        cnt_q <= cnt_q - CNT_ONE;
        if (cnt_q == CNT_ONE) begin
          expire_q <= 1'b1;
        end
      end
    end
  end
  assign expire = expire_q;
endmodule : iafp_unlock_timer

// ===== test/iafp_flash_model.sv
// flash array model: page erase, word-wise page program, word read
`timescale 1ns/100ps
module iafp_flash_model #(
  parameter int DLY = 5
) (
  // system
  input wire logic clock,
  // strobes
  input wire logic flashWrStb,
  input wire logic flashEraseStb,
  input wire logic flashRdStb,
  input wire logic [14:0] flashAddr,
  input wire logic [15:0] flashWdata,
  // answer
  output logic flashDone,
  output logic [15:0] flashRdData
);
  logic [15:0] mem [int];
  logic [14:0] lastRdAddr = 15'h0;
  logic rdPend = 1'b0;
  int wrCnt = 0;
  int busy = 0;
  initial flashDone = 1'b0;
  initial flashRdData = 16'h0;
  function automatic logic [15:0] rdMem(input logic [14:0] a);
    return mem.exists(a) ? mem[a] : 16'hffff;
  endfunction : rdMem
  always @(posedge clock) begin
    flashDone <= 1'b0;
    // stale read data never holds
    flashRdData <= ~flashRdData;
    if (flashWrStb) begin
      // programming only clears bits, so an unerased page corrupts
      mem[flashAddr] = rdMem(flashAddr) & flashWdata;
      wrCnt++;
      if (wrCnt == 64) busy = DLY;
    end
    if (flashEraseStb) begin
      for (int k = 0; k < 64; k++) mem[{flashAddr[14:6], 6'(k)}] = 16'hffff;
      busy = DLY;
    end
    if (flashRdStb) begin
      lastRdAddr = flashAddr;
      rdPend = 1'b1;
      busy = DLY;
    end
    if (busy > 0) begin
      busy--;
      if (busy == 0) begin
        flashDone <= 1'b1;
        wrCnt = 0;
        if (rdPend) flashRdData <= rdMem(lastRdAddr);
        rdPend = 1'b0;
      end
    end
  end
endmodule : iafp_flash_model

// ===== test/tb_iafp_top.sv
// testbench: register-level tests of the flash programmer
`timescale 1ns/100ps
module tb_iafp_top;
  import iafp_pkg::*;
  localparam int UCYC = 16;
  logic clock, nrst, sfrWr, sfrSector, cpuStall, flashWrStb, flashEraseStb, flashRdStb;
  logic flashTimeSel, flashDone, stallSeen;
  logic [7:0] sfrAddr, sfrWdata, sfrRdata, rv, hi;
  logic [14:0] flashAddr;
  logic [15:0] flashWdata, flashRdData;
  int miscompares, checks_done, i;
  iafp_top #(.UNLOCK_CYCLES(UCYC)) dut_u (.clock(clock), .nrst(nrst), .sfrWr(sfrWr),
    .sfrSector(sfrSector), .sfrAddr(sfrAddr), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
    .cpuStall(cpuStall), .flashWrStb(flashWrStb), .flashEraseStb(flashEraseStb),
    .flashRdStb(flashRdStb), .flashAddr(flashAddr), .flashWdata(flashWdata),
    .flashTimeSel(flashTimeSel), .flashDone(flashDone), .flashRdData(flashRdData));
  iafp_flash_model flash_u (.clock(clock), .flashWrStb(flashWrStb),
    .flashEraseStb(flashEraseStb), .flashRdStb(flashRdStb), .flashAddr(flashAddr),
    .flashWdata(flashWdata), .flashDone(flashDone), .flashRdData(flashRdData));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task summarize;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task wr(input logic s, input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    sfrWr = 1'b1;
    sfrSector = s;
    sfrAddr = a;
    sfrWdata = d;
    @(negedge clock);
    sfrWr = 1'b0;
  endtask : wr
  task rd(input logic s, input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    sfrSector = s;
    sfrAddr = a;
    @(negedge clock);
    d = sfrRdata;
    stallSeen = stallSeen | (cpuStall === 1'b1);
  endtask : rd
  task rdchk(input logic s, input logic [7:0] a, input logic [7:0] exp);
    rd(s, a, rv);
    check(16'(rv), 16'(exp));
  endtask : rdchk
  // poll one bit of a control register until it reaches val
  task waitBit(input logic [7:0] a, input int b, input logic val);
    int n;
    n = 0;
    rd(SECTOR_EXT, a, rv);
    while (rv[b] !== val && n < 400) begin
      rd(SECTOR_EXT, a, rv);
      n++;
    end
    if (n >= 400) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, rv, val);
      summarize();
    end
  endtask : waitBit
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    sfrWr = 1'b0;
    sfrSector = 1'b0;
    sfrAddr = 8'h00;
    sfrWdata = 8'h00;
    miscompares = 0;
    checks_done = 0;
    stallSeen = 1'b0;
    repeat (20) @(negedge clock);
    nrst = 1'b1;
    rdchk(SECTOR_DIRECT, OFS_ADDR_LO, REG_RESET);
    rdchk(SECTOR_EXT, OFS_CTRL0, REG_RESET);
    wr(SECTOR_DIRECT, OFS_ADDR_HI, 8'hff);
    rdchk(SECTOR_DIRECT, OFS_ADDR_HI, 8'h7f);
    rdchk(SECTOR_DIRECT, 8'h0a, 8'h00);
    wr(SECTOR_EXT, OFS_CTRL1, 8'ha5);
    rdchk(SECTOR_EXT, OFS_CTRL1, 8'ha5);
    wr(SECTOR_EXT, OFS_CTRL2, 8'h02);
    rdchk(SECTOR_EXT, OFS_CTRL2, 8'h02);
    check(16'(flashTimeSel), 16'h0001);
    $display("test registers done");
    wr(SECTOR_DIRECT, OFS_ADDR_LO, 8'h00);
    wr(SECTOR_DIRECT, 8'h03, 8'h77);
    rdchk(SECTOR_DIRECT, OFS_ADDR_LO, 8'h00);
    wr(SECTOR_EXT, OFS_CTRL0, 8'h84);
    rdchk(SECTOR_EXT, OFS_CTRL0, 8'h00);
    // unlock without patterns: trigger must time out
    wr(SECTOR_EXT, OFS_CTRL0, 8'h68);
    repeat (UCYC + 4) @(negedge clock);
    rdchk(SECTOR_EXT, OFS_CTRL0, 8'h60);
    wr(SECTOR_DIRECT, 8'h04, 8'h11);
    wr(SECTOR_DIRECT, 8'h05, 8'h11);
    wr(SECTOR_DIRECT, 8'h06, 8'h22);
    wr(SECTOR_DIRECT, 8'h07, 8'h22);
    wr(SECTOR_DIRECT, 8'h08, 8'h33);
    wr(SECTOR_DIRECT, 8'h09, 8'h33);
    wr(SECTOR_EXT, OFS_CTRL0, 8'h68);
    waitBit(OFS_CTRL0, C0_ENABLED, 1'b1);
    rdchk(SECTOR_EXT, OFS_CTRL0, 8'he0);
    $display("test unlock done");
    wr(SECTOR_EXT, OFS_CTRL2, 8'h01);
    waitBit(OFS_CTRL2, C2_CLR, 1'b0);
    wr(SECTOR_DIRECT, OFS_ADDR_HI, 8'h12);
    wr(SECTOR_DIRECT, OFS_ADDR_LO, 8'h80);
    wr(SECTOR_EXT, OFS_CTRL0, 8'h94);
    waitBit(OFS_CTRL0, C0_PROG, 1'b0);
    check(flash_u.rdMem(15'h12bf), 16'hffff);
    check(16'(flashAddr), 16'h1280);
    for (i = 0; i < 65; i++) begin
      wr(SECTOR_DIRECT, 8'h02, 8'(i));
      wr(SECTOR_DIRECT, 8'h03, 8'h5a);
    end
    rdchk(SECTOR_DIRECT, OFS_ADDR_LO, 8'hbf);
    wr(SECTOR_EXT, OFS_CTRL0, 8'h84);
    waitBit(OFS_CTRL0, C0_PROG, 1'b0);
    check(dut_u.u_buf.mem[1], 16'h0000);
    for (i = 0; i < 63; i++) begin
      check(flash_u.rdMem(15'h1280 + 15'(i)), 16'h5a00 + 16'(i));
    end
    check(flash_u.rdMem(15'h12bf), 16'h5a40);
    check(flash_u.rdMem(15'h12c0), 16'hffff);
    $display("test erase program done");
    wr(SECTOR_DIRECT, OFS_ADDR_LO, 8'h85);
    wr(SECTOR_EXT, OFS_CTRL0, 8'hb1);
    rdchk(SECTOR_EXT, OFS_CTRL0, 8'hb0);
    wr(SECTOR_EXT, OFS_CTRL0, 8'hb2);
    stallSeen = 1'b0;
    wr(SECTOR_EXT, OFS_CTRL0, 8'hb3);
    waitBit(OFS_CTRL0, C0_RD, 1'b0);
    check(16'(stallSeen), 16'h0001);
    check(16'(flash_u.lastRdAddr), 16'h1285);
    rd(SECTOR_DIRECT, 8'h03, hi);
    rd(SECTOR_DIRECT, 8'h02, rv);
    check({hi, rv}, 16'h5a05);
    $display("test read done");
    // bad verify: clear by hand, reload, erase and program again
    wr(SECTOR_EXT, OFS_CTRL2, 8'h01);
    waitBit(OFS_CTRL2, C2_CLR, 1'b0);
    wr(SECTOR_DIRECT, OFS_ADDR_LO, 8'h80);
    wr(SECTOR_DIRECT, 8'h02, 8'h34);
    wr(SECTOR_DIRECT, 8'h03, 8'h12);
    wr(SECTOR_EXT, OFS_CTRL0, 8'h94);
    waitBit(OFS_CTRL0, C0_PROG, 1'b0);
    wr(SECTOR_EXT, OFS_CTRL0, 8'h84);
    waitBit(OFS_CTRL0, C0_PROG, 1'b0);
    check(flash_u.rdMem(15'h1280), 16'h1234);
    check(flash_u.rdMem(15'h1281), 16'h0000);
    $display("test reprogram done");
    wr(SECTOR_EXT, OFS_CTRL0, 8'h00);
    rdchk(SECTOR_EXT, OFS_CTRL0, 8'h00);
    wr(SECTOR_EXT, OFS_CTRL0, 8'h04);
    rdchk(SECTOR_EXT, OFS_CTRL0, 8'h00);
    $display("test disable done");
    summarize();
  end
endmodule : tb_iafp_top
